//--- shared/nfc_pkg.sv
/*
  Shared constants for the NOR flash host controller: command words, unlock
  addresses, register offsets, field positions and bus cycle timing.
  Assumes a 16-bit asynchronous NOR flash outside, with 19 word-address pins.
*/
package nfc_pkg;
  // ----------------------------------------------------------------
  // Flash geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int CMD_ADDR_W = 11;

  // ----------------------------------------------------------------
  // Command addresses and data
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 19'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 19'h002aa;
  localparam logic [ADDR_W-1:0] QUERY_ADDR = 19'h00055;
  localparam logic [ADDR_W-1:0] ID_MAKER_OFS = 19'h00000;
  localparam logic [ADDR_W-1:0] ID_DEVICE_OFS = 19'h00001;
  localparam logic [ADDR_W-1:0] ID_PROTECT_OFS = 19'h00002;
  localparam logic [DATA_W-1:0] UNLOCK1_DATA = 16'h00aa;
  localparam logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_RESET = 16'h00f0;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00a0;
  localparam logic [DATA_W-1:0] CMD_IDENT = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_BLOCK_ERASE = 16'h0050;
  localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 16'h0010;
  localparam logic [DATA_W-1:0] CMD_SUSPEND = 16'h00b0;
  localparam logic [DATA_W-1:0] CMD_RESUME = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_QUERY = 16'h0098;

  // ----------------------------------------------------------------
  // Status bits seen on the data pins while busy
  // ----------------------------------------------------------------
  localparam int INV_DATA_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TIMEOUT_BIT = 5;
  localparam int ERASE_TOGGLE_BIT = 2;

  // ----------------------------------------------------------------
  // Operation codes written to the command register
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    NFC_OP_READ = 4'h0,
    NFC_OP_RESET = 4'h1,
    NFC_OP_PROGRAM = 4'h2,
    NFC_OP_IDENT = 4'h3,
    NFC_OP_SECTOR_ERASE = 4'h4,
    NFC_OP_BLOCK_ERASE = 4'h5,
    NFC_OP_CHIP_ERASE = 4'h6,
    NFC_OP_SUSPEND = 4'h7,
    NFC_OP_RESUME = 4'h8,
    NFC_OP_QUERY = 4'h9,
    NFC_OP_RAW_WRITE = 4'ha
  } nfc_op_t;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_ADDR = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_POLL_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_FAIL_BIT = 2;
  localparam int STAT_PROT_BIT = 3;

  // ----------------------------------------------------------------
  // Bus cycle timing, in clock cycles at 50 MHz
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_ACCESS_NS = 70;
  localparam int T_WRPULSE_NS = 50;
  localparam int T_RECOVER_NS = 30;
  localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
  localparam int WRPULSE_CYC = (T_WRPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
endpackage

//--- rtl/nfc_bus_cycle.sv
/*
  One flash bus cycle: a read or a write on the chip select, write and output
  strobes. Assumes the pins face an asynchronous flash and data in is raw.
*/
`timescale 1ns/1ps
module nfc_bus_cycle #(
  parameter int AW = nfc_pkg::ADDR_W,
  parameter int DW = nfc_pkg::DATA_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic done_o,
  output logic [DW-1:0] rdata_o,
  output logic cs_n_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic [AW-1:0] addr_o,
  output logic [DW-1:0] dq_o,
  output logic dq_oe_n_o,
  input wire logic [DW-1:0] dq_i
);
  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    NFC_BC_IDLE = 4'b0001,
    NFC_BC_SETUP = 4'b0010,
    NFC_BC_PULSE = 4'b0100,
    NFC_BC_HOLD = 4'b1000
  } nfc_bc_state_t;

  nfc_bc_state_t state_r;
  logic [nfc_pkg::CNT_W-1:0] cnt_r;
  logic write_r;
  logic [DW-1:0] dq_s1_r;
  logic [DW-1:0] dq_s2_r;

  // Two-flop synchroniser on the data pins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else begin
      dq_s1_r <= dq_i;
      dq_s2_r <= dq_s1_r;
    end
  end

  // Strobes: write asserts chip select and write with output strobe high
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= NFC_BC_IDLE;
      cnt_r <= '0;
      write_r <= 1'b0;
      cs_n_o <= 1'b1;
      we_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      addr_o <= '0;
      dq_o <= '0;
      dq_oe_n_o <= 1'b1;
      done_o <= 1'b0;
      rdata_o <= '0;
    end else begin
      done_o <= 1'b0;
      unique case (state_r)
        NFC_BC_IDLE: begin
          if (start_i) begin
            write_r <= write_i;
            addr_o <= addr_i;
            dq_o <= wdata_i;
            dq_oe_n_o <= !write_i;
            oe_n_o <= 1'b1;
            state_r <= NFC_BC_SETUP;
          end
        end
        NFC_BC_SETUP: begin
          cs_n_o <= 1'b0;
          we_n_o <= !write_r;
          oe_n_o <= write_r;
          cnt_r <= write_r ? nfc_pkg::CNT_W'(nfc_pkg::WRPULSE_CYC)
                           : nfc_pkg::CNT_W'(nfc_pkg::ACCESS_CYC);
          state_r <= NFC_BC_PULSE;
        end
        NFC_BC_PULSE: begin
          if (cnt_r > 1) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            rdata_o <= dq_s2_r;
            cs_n_o <= 1'b1;
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            cnt_r <= nfc_pkg::CNT_W'(nfc_pkg::RECOVER_CYC);
            state_r <= NFC_BC_HOLD;
          end
        end
        NFC_BC_HOLD: begin
          if (cnt_r > 1) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            dq_oe_n_o <= 1'b1;
            done_o <= 1'b1;
            state_r <= NFC_BC_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_no_rw_overlap: assert property (@(posedge clk_i) disable iff (rst_i)
    !(!we_n_o && !oe_n_o)) else $error("Write and output strobes both low");
  a_write_drives: assert property (@(posedge clk_i) disable iff (rst_i)
    !we_n_o |-> !dq_oe_n_o && !cs_n_o) else $error("Write strobe without data drive");
endmodule

//--- rtl/nfc_host_ctrl.sv
/*
  Host controller for a 16-bit NOR flash: software orders whole command
  sequences over APB, the controller issues the unlock cycles and polls.
  Assumes APB on clk_i and a flash on the pin group, one cycle at a time.
*/
`timescale 1ns/1ps
module nfc_host_ctrl #(
  parameter int AW = nfc_pkg::ADDR_W,
  parameter int DW = nfc_pkg::DATA_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic flash_cs_n_o,
  output logic flash_we_n_o,
  output logic flash_oe_n_o,
  output logic [AW-1:0] flash_addr_o,
  output logic [DW-1:0] flash_dq_o,
  output logic flash_dq_oe_n_o,
  input wire logic [DW-1:0] flash_dq_i
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    NFC_ST_IDLE = 6'b000001,
    NFC_ST_SEND = 6'b000010,
    NFC_ST_WAIT = 6'b000100,
    NFC_ST_POLL = 6'b001000,
    NFC_ST_PWAIT = 6'b010000,
    NFC_ST_FIN = 6'b100000
  } nfc_state_t;

  nfc_state_t state_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] wdata_r;
  logic [DW-1:0] rdata_r;
  nfc_pkg::nfc_op_t op_r;
  logic poll_r;
  logic busy_r;
  logic done_r;
  logic fail_r;
  logic [2:0] step_r;
  logic [2:0] nsteps_r;
  logic [DW-1:0] last_poll_r;
  logic poll_first_r;
  logic bc_start_r;
  logic bc_write_r;
  logic [AW-1:0] bc_addr_r;
  logic [DW-1:0] bc_wdata_r;
  logic bc_done;
  logic [DW-1:0] bc_rdata;
  logic apb_wr;
  logic apb_rd;
  logic cmd_hit;

  // Sequence length of each operation
  function automatic logic [2:0] nfc_len(input nfc_pkg::nfc_op_t op);
    unique case (op)
      nfc_pkg::NFC_OP_PROGRAM: nfc_len = 3'd4;
      nfc_pkg::NFC_OP_IDENT: nfc_len = 3'd3;
      nfc_pkg::NFC_OP_SECTOR_ERASE,
      nfc_pkg::NFC_OP_BLOCK_ERASE,
      nfc_pkg::NFC_OP_CHIP_ERASE: nfc_len = 3'd6;
      default: nfc_len = 3'd1;
    endcase
  endfunction

  // Address of one write cycle in a sequence
  function automatic logic [AW-1:0] nfc_seq_addr(input nfc_pkg::nfc_op_t op,
      input logic [2:0] step, input logic [AW-1:0] tgt);
    nfc_seq_addr = tgt;
    if (nfc_len(op) > 3'd1) begin
      unique case (step)
        3'd0, 3'd3: nfc_seq_addr = nfc_pkg::UNLOCK1_ADDR;
        3'd1, 3'd4: nfc_seq_addr = nfc_pkg::UNLOCK2_ADDR;
        3'd2: nfc_seq_addr = nfc_pkg::UNLOCK1_ADDR;
        default: nfc_seq_addr = (op == nfc_pkg::NFC_OP_CHIP_ERASE) ?
            nfc_pkg::UNLOCK1_ADDR : tgt;
      endcase
      if (step == 3'd3 && op == nfc_pkg::NFC_OP_PROGRAM) begin
        nfc_seq_addr = tgt;
      end
    end else if (op == nfc_pkg::NFC_OP_QUERY) begin
      nfc_seq_addr = nfc_pkg::QUERY_ADDR;
    end
  endfunction

  // Data of one write cycle in a sequence
  function automatic logic [DW-1:0] nfc_seq_data(input nfc_pkg::nfc_op_t op,
      input logic [2:0] step, input logic [DW-1:0] wd);
    nfc_seq_data = wd;
    unique case (op)
      nfc_pkg::NFC_OP_RESET: nfc_seq_data = nfc_pkg::CMD_RESET;
      nfc_pkg::NFC_OP_SUSPEND: nfc_seq_data = nfc_pkg::CMD_SUSPEND;
      nfc_pkg::NFC_OP_RESUME: nfc_seq_data = nfc_pkg::CMD_RESUME;
      nfc_pkg::NFC_OP_QUERY: nfc_seq_data = nfc_pkg::CMD_QUERY;
      default: nfc_seq_data = wd;
    endcase
    if (nfc_len(op) > 3'd1) begin
      unique case (step)
        3'd0, 3'd3: nfc_seq_data = nfc_pkg::UNLOCK1_DATA;
        3'd1, 3'd4: nfc_seq_data = nfc_pkg::UNLOCK2_DATA;
        3'd2: begin
          if (op == nfc_pkg::NFC_OP_PROGRAM) nfc_seq_data = nfc_pkg::CMD_PROGRAM;
          else if (op == nfc_pkg::NFC_OP_IDENT) nfc_seq_data = nfc_pkg::CMD_IDENT;
          else nfc_seq_data = nfc_pkg::CMD_ERASE_SETUP;
        end
        default: begin
          if (op == nfc_pkg::NFC_OP_SECTOR_ERASE) nfc_seq_data = nfc_pkg::CMD_SECTOR_ERASE;
          else if (op == nfc_pkg::NFC_OP_BLOCK_ERASE) nfc_seq_data = nfc_pkg::CMD_BLOCK_ERASE;
          else if (op == nfc_pkg::NFC_OP_CHIP_ERASE) nfc_seq_data = nfc_pkg::CMD_CHIP_ERASE;
          else nfc_seq_data = wd; // program word
        end
      endcase
      // Fourth program cycle carries the word itself, not a second unlock
      if (step == 3'd3 && op == nfc_pkg::NFC_OP_PROGRAM) begin
        nfc_seq_data = wd;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // APB slave: zero wait states, unmapped reads return zero
  // ----------------------------------------------------------------
  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign apb_rd = psel_i && !pwrite_i;
  assign cmd_hit = apb_wr && (paddr_i == nfc_pkg::REG_CMD) && !busy_r;

  // Address and write data registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_r <= '0;
      wdata_r <= '0;
    end else if (apb_wr && !busy_r) begin
      if (paddr_i == nfc_pkg::REG_ADDR) addr_r <= pwdata_i[AW-1:0];
      if (paddr_i == nfc_pkg::REG_WDATA) wdata_r <= pwdata_i[DW-1:0];
    end
  end

  // Read data mux, registered
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= '0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
      if (apb_rd) begin
        unique case (paddr_i)
          nfc_pkg::REG_ADDR: prdata_o <= 32'(addr_r);
          nfc_pkg::REG_WDATA: prdata_o <= 32'(wdata_r);
          nfc_pkg::REG_CMD: prdata_o <= {23'h000000, poll_r, 4'h0, op_r};
          nfc_pkg::REG_STATUS: prdata_o <= {28'h0000000, rdata_r[0], fail_r, done_r, busy_r};
          nfc_pkg::REG_RDATA: prdata_o <= 32'(rdata_r);
          default: prdata_o <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: one order becomes its cycles, then optional polling
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= NFC_ST_IDLE;
      op_r <= nfc_pkg::NFC_OP_READ;
      poll_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      step_r <= '0;
      nsteps_r <= '0;
      rdata_r <= '0;
      last_poll_r <= '0;
      poll_first_r <= 1'b0;
      bc_start_r <= 1'b0;
      bc_write_r <= 1'b0;
      bc_addr_r <= '0;
      bc_wdata_r <= '0;
    end else begin
      bc_start_r <= 1'b0;
      unique case (state_r)
        NFC_ST_IDLE: begin
          if (cmd_hit) begin
            op_r <= nfc_pkg::nfc_op_t'(pwdata_i[nfc_pkg::CMD_OP_LSB +: 4]);
            poll_r <= pwdata_i[nfc_pkg::CMD_POLL_BIT];
            nsteps_r <= nfc_len(nfc_pkg::nfc_op_t'(pwdata_i[nfc_pkg::CMD_OP_LSB +: 4]));
            step_r <= '0;
            busy_r <= 1'b1;
            done_r <= 1'b0; // Cleared here: a new order clears done
            fail_r <= 1'b0;
            state_r <= NFC_ST_SEND;
          end
        end
        NFC_ST_SEND: begin
          bc_start_r <= 1'b1;
          bc_write_r <= (op_r != nfc_pkg::NFC_OP_READ);
          bc_addr_r <= nfc_seq_addr(op_r, step_r, addr_r);
          bc_wdata_r <= nfc_seq_data(op_r, step_r, wdata_r);
          state_r <= NFC_ST_WAIT;
        end
        NFC_ST_WAIT: begin
          if (bc_done) begin
            if (op_r == nfc_pkg::NFC_OP_READ) rdata_r <= bc_rdata;
            if (step_r + 3'd1 < nsteps_r) begin
              step_r <= step_r + 3'd1; // exact order, no gaps
              state_r <= NFC_ST_SEND;
            end else if (poll_r) begin
              poll_first_r <= 1'b1;
              state_r <= NFC_ST_POLL;
            end else begin
              state_r <= NFC_ST_FIN;
            end
          end
        end
        NFC_ST_POLL: begin
          bc_start_r <= 1'b1;
          bc_write_r <= 1'b0;
          bc_addr_r <= addr_r;
          state_r <= NFC_ST_PWAIT;
        end
        NFC_ST_PWAIT: begin
          if (bc_done) begin
            last_poll_r <= bc_rdata;
            rdata_r <= bc_rdata;
            poll_first_r <= 1'b0;
            if (!poll_first_r &&
                bc_rdata[nfc_pkg::TOGGLE_BIT] == last_poll_r[nfc_pkg::TOGGLE_BIT]) begin
              state_r <= NFC_ST_FIN; // toggle stopped
            end else if (!poll_first_r && bc_rdata[nfc_pkg::TIMEOUT_BIT]) begin
              fail_r <= 1'b1; // software must send reset
              state_r <= NFC_ST_FIN;
            end else begin
              state_r <= NFC_ST_POLL; // no writes while busy
            end
          end
        end
        NFC_ST_FIN: begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          state_r <= NFC_ST_IDLE;
        end
        default: state_r <= NFC_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin driver
  // ----------------------------------------------------------------
  nfc_bus_cycle #(
    .AW(AW),
    .DW(DW)
  ) u_cycle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(bc_start_r),
    .write_i(bc_write_r),
    .addr_i(bc_addr_r),
    .wdata_i(bc_wdata_r),
    .done_o(bc_done),
    .rdata_o(bc_rdata),
    .cs_n_o(flash_cs_n_o),
    .we_n_o(flash_we_n_o),
    .oe_n_o(flash_oe_n_o),
    .addr_o(flash_addr_o),
    .dq_o(flash_dq_o),
    .dq_oe_n_o(flash_dq_oe_n_o),
    .dq_i(flash_dq_i)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_first_unlock: assert property (@(posedge clk_i) disable iff (rst_i)
    bc_start_r && nsteps_r > 3'd1 && step_r == 3'd0 |->
    bc_write_r && bc_addr_r == nfc_pkg::UNLOCK1_ADDR && bc_wdata_r == nfc_pkg::UNLOCK1_DATA)
    else $error("First unlock cycle wrong");
  a_second_unlock: assert property (@(posedge clk_i) disable iff (rst_i)
    bc_start_r && nsteps_r > 3'd1 && step_r == 3'd1 |->
    bc_addr_r == nfc_pkg::UNLOCK2_ADDR && bc_wdata_r == nfc_pkg::UNLOCK2_DATA)
    else $error("Second unlock cycle wrong");
  a_reset_data: assert property (@(posedge clk_i) disable iff (rst_i)
    bc_start_r && bc_write_r && op_r == nfc_pkg::NFC_OP_RESET |->
    bc_wdata_r == nfc_pkg::CMD_RESET) else $error("Reset word wrong");
  a_program_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
    bc_start_r && op_r == nfc_pkg::NFC_OP_PROGRAM && step_r == 3'd2 |->
    bc_wdata_r == nfc_pkg::CMD_PROGRAM) else $error("Program setup wrong");
  a_ident_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
    bc_start_r && op_r == nfc_pkg::NFC_OP_IDENT && step_r == 3'd2 |->
    bc_wdata_r == nfc_pkg::CMD_IDENT) else $error("Ident command wrong");
  a_chip_last: assert property (@(posedge clk_i) disable iff (rst_i)
    bc_start_r && bc_write_r && op_r == nfc_pkg::NFC_OP_CHIP_ERASE && step_r == 3'd5 |->
    bc_addr_r == nfc_pkg::UNLOCK1_ADDR && bc_wdata_r == nfc_pkg::CMD_CHIP_ERASE)
    else $error("Chip erase command wrong");
  a_sector_last: assert property (@(posedge clk_i) disable iff (rst_i)
    bc_start_r && op_r == nfc_pkg::NFC_OP_SECTOR_ERASE && step_r == 3'd5 |->
    bc_addr_r == addr_r && bc_wdata_r == nfc_pkg::CMD_SECTOR_ERASE)
    else $error("Sector erase command wrong");
  a_poll_reads: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == NFC_ST_POLL |=> bc_start_r && !bc_write_r)
    else $error("Polling issued a write");
  a_done_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == NFC_ST_FIN |=> !busy_r && done_r) else $error("Done not reported");

  c_program: cover property (@(posedge clk_i) disable iff (rst_i)
    bc_start_r && op_r == nfc_pkg::NFC_OP_PROGRAM && step_r == 3'd3);
  c_chip_erase: cover property (@(posedge clk_i) disable iff (rst_i)
    bc_start_r && op_r == nfc_pkg::NFC_OP_CHIP_ERASE && step_r == 3'd5);
  c_timeout: cover property (@(posedge clk_i) disable iff (rst_i) fail_r);
  c_read: cover property (@(posedge clk_i) disable iff (rst_i)
    state_r == NFC_ST_FIN && op_r == nfc_pkg::NFC_OP_READ);
endmodule

//--- verification/nfc_flash_model.sv
/* Behavioural 16-bit NOR flash that answers the host controller's pins.
   Assumes the bench resolves dq; each read while busy drains one busy step. */
`timescale 1ns/1ps
module nfc_flash_model #(
  parameter logic [15:0] MAKER = 16'h00a5, // Arbitrary value
  parameter logic [15:0] DEVICE = 16'h005a // Arbitrary value
) (
  input wire logic cs_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [18:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o
);
  logic [15:0] mem [logic [18:0]];
  logic [18:0] adr;
  logic [15:0] last = 16'h0000;
  logic [15:0] st = 16'h0000;
  int step = 0;
  int busy = 0;
  bit idm = 0;
  wire wr = !cs_n_i && !we_n_i && oe_n_i;
  wire rd = !cs_n_i && !oe_n_i;
  wire cmd = adr[10:0] == 11'h555;
  // Released bus shows the inverse of the last word
  assign dq_o = rd ? last : ~last;
  function automatic logic [15:0] arr(input logic [18:0] a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  // Address at the later falling strobe
  always @(posedge wr) adr = addr_i;
  // Decode at the earlier rising strobe; nothing is taken while busy
  always @(negedge wr) if (busy == 0) begin
    if (dq_i[7:0] == 8'hf0) begin
      step = 0;
      idm = 0;
    end else begin
      if (step == 2 && cmd && dq_i[7:0] == 8'h90) idm = 1;
      case (step)
        0, 3: step = cmd && dq_i[7:0] == 8'haa ? step + 1 : 0;
        1, 4: step = adr[10:0] == 11'h2aa && dq_i[7:0] == 8'h55 ? step + 1 : 0;
        2: step = !cmd ? 0 : dq_i[7:0] == 8'ha0 ? 6 : dq_i[7:0] == 8'h80 ? 3 : 0;
        5: begin
          foreach (mem[k]) if (dq_i[7:0] == 8'h10 || dq_i[7:0] == 8'h30 &&
              k[18:11] == adr[18:11] || dq_i[7:0] == 8'h50 && k[18:15] == adr[18:15])
            mem[k] = 16'hffff;
          busy = 3;
          step = 0;
        end
        default: begin
          mem[adr] = arr(adr) & dq_i;
          busy = 3;
          step = 0;
        end
      endcase
    end
  end
  // Busy reads give toggling status, then array or identification words
  always @(posedge rd) if (busy > 0) begin
    busy--;
    st[6] = ~st[6];
    last = st;
  end else begin
    last = !idm ? arr(addr_i) : addr_i[1:0] == 2'h0 ? MAKER :
        addr_i[1:0] == 2'h1 ? DEVICE : 16'h0000;
  end
endmodule

//--- verification/nfc_host_ctrl_tb_top.sv
/* Bench for the NOR flash host controller: APB master, flash model, row table.
   Assumes the shared package and the flash model are compiled first. */
`timescale 1ns/1ps
module nfc_host_ctrl_tb_top;
  typedef struct packed {
    logic [3:0] o;
    logic [18:0] a;
    logic [15:0] d;
    logic [18:0] c;
    logic [15:0] e;
  } nfc_row_t;
  logic clk_i = 0;
  logic rst_i = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, cs_n, we_n, oe_n, dq_oe_n;
  logic [18:0] fa;
  logic [15:0] cdq, mdq;
  wire [15:0] dq_w = dq_oe_n ? mdq : cdq;
  int n_errors = 0;
  int check_count = 0;
  nfc_row_t rows [11] = '{
    '{4'h2, 19'h10, 16'h1234, 19'h10, 16'h1234},
    '{4'h2, 19'h10, 16'hff0f, 19'h10, 16'h1204},
    '{4'h4, 19'h10, 16'h0, 19'h10, 16'hffff},
    '{4'h2, 19'h8000, 16'h5555, 19'h8000, 16'h5555},
    '{4'h5, 19'h8000, 16'h0, 19'h8000, 16'hffff},
    '{4'h2, 19'h20, 16'h0, 19'h20, 16'h0},
    '{4'h6, 19'h0, 16'h0, 19'h20, 16'hffff},
    '{4'h3, 19'h0, 16'h0, 19'h0, 16'h00a5},
    '{4'h0, 19'h1, 16'h0, 19'h1, 16'h005a},
    '{4'h0, 19'h2, 16'h0, 19'h2, 16'h0},
    '{4'h1, 19'h0, 16'h0, 19'h20, 16'hffff}};
  always #10 clk_i = ~clk_i;
  nfc_host_ctrl u_nfc_host_ctrl (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(), .flash_cs_n_o(cs_n),
    .flash_we_n_o(we_n), .flash_oe_n_o(oe_n), .flash_addr_o(fa), .flash_dq_o(cdq),
    .flash_dq_oe_n_o(dq_oe_n), .flash_dq_i(dq_w));
  nfc_flash_model u_nfc_flash_model (.cs_n_i(cs_n), .we_n_i(we_n), .oe_n_i(oe_n),
    .addr_i(fa), .dq_i(dq_w), .dq_o(mdq));
  task automatic fail(input string m);
    n_errors++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One APB transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail("no pready");
      end_of_test();
    end
    r = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge clk_i);
  endtask
  // Order one operation and wait until busy clears
  task automatic op(input logic [3:0] o, input logic [18:0] a, input logic [15:0] d,
      input logic p);
    logic [31:0] r;
    int n;
    apb(1, nfc_pkg::REG_ADDR, {13'h0, a}, r);
    apb(1, nfc_pkg::REG_WDATA, {16'h0, d}, r);
    apb(1, nfc_pkg::REG_CMD, {23'h0, p, 4'h0, o}, r);
    n = 0;
    do begin
      apb(0, nfc_pkg::REG_STATUS, 32'h0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 400);
    if (n >= 400) begin
      fail("busy stuck");
      end_of_test();
    end
    check_count++;
    if (r[1] !== 1'b1) fail("done not reported");
  endtask
  task automatic raw(input logic [18:0] a, input logic [15:0] d);
    op(nfc_pkg::NFC_OP_RAW_WRITE, a, d, 1'b0);
  endtask
  task automatic unl(input logic [18:0] h, input logic [15:0] d2);
    raw(h | 19'h555, 16'h00aa);
    raw(h | 19'h2aa, d2);
  endtask
  task automatic chk(input logic [18:0] a, input logic [15:0] e);
    logic [31:0] r;
    op(nfc_pkg::NFC_OP_READ, a, 16'h0, 1'b1);
    apb(0, nfc_pkg::REG_RDATA, 32'h0, r);
    check_count++;
    if (r[15:0] !== e) fail("read data mismatch");
  endtask
  // Reset, table rows, then the awkward cases
  initial begin
    logic [31:0] r;
    repeat (4) @(posedge clk_i);
    check_count++;
    if (cs_n !== 1'b1 || dq_oe_n !== 1'b1 || pready !== 1'b0) fail("reset state");
    rst_i <= 0;
    @(posedge clk_i);
    foreach (rows[i]) begin
      op(rows[i].o, rows[i].a, rows[i].d, rows[i].o inside {4'h2, 4'h4, 4'h5, 4'h6});
      chk(rows[i].c, rows[i].e);
    end
    unl(19'h40000, 16'h0055);
    raw(19'h40555, 16'h00a0);
    raw(19'h30, 16'h00ab);
    chk(19'h30, 16'h00ab);
    unl(19'h0, 16'h0054);
    raw(19'h555, 16'h00a0);
    raw(19'h30, 16'h0000);
    chk(19'h30, 16'h00ab);
    unl(19'h0, 16'h0055);
    op(nfc_pkg::NFC_OP_RESET, 19'h0, 16'h0, 1'b0);
    raw(19'h555, 16'h0090);
    chk(19'h1, 16'hffff);
    unl(19'h0, 16'h0055);
    raw(19'h555, 16'h00a0);
    raw(19'h40, 16'h0f0f);
    op(nfc_pkg::NFC_OP_RESET, 19'h0, 16'h0, 1'b0);
    chk(19'h40, 16'h0f0f);
    apb(0, 8'h20, 32'h0, r);
    check_count++;
    if (r !== 32'h0) fail("unmapped read not zero");
    end_of_test();
  end
endmodule
